// ===== rtl/dus_map.vh
// Overview of operation
// [R1] Command 22 followed by one byte stores the update option used by the next activation.
// [R2] Option 91: clock on, mode-1 table load, clock off; B1 adds temperature load.
// [R3] Option 99: clock on, mode-2 table load, clock off; B9 adds temperature load.
// [R4] Option C7: clock on, analog on, mode-1 display, analog off, oscillator off.
// [R5] Option CF: clock on, analog on, mode-2 display, analog off, oscillator off.
// [R6] Four-bit RAM option per plane: 0000 normal, 0100 forced zero, 1000 inverted.
// [R7] Command 20 runs the chosen sequence with busy high; host waits for busy low.
// [R8] Black-white plane: 1 white, 0 black; red plane: 1 red, 0 black or white.
// [R9] Host sends commands with data-command low and their parameters with it high.
`ifndef DUS_MAP_VH
`define DUS_MAP_VH

// register byte offsets
`define DUS_OFF_TX      12'h000
`define DUS_OFF_CTRL1   12'h004
`define DUS_OFF_CTRL2   12'h008
`define DUS_OFF_STAT    12'h00C

// byte-port and status fields
`define DUS_TX_DC_BIT   8
`define DUS_STAT_BUSY   0
`define DUS_STAT_DROP   1

// command codes
`define DUS_CMD_ACT     8'h20
`define DUS_CMD_UPD1    8'h21
`define DUS_CMD_UPD2    8'h22

// reset values
`define DUS_RST_OPT2    8'hFF
`define DUS_RST_RAMA    8'h00
`define DUS_RST_RAMB    8'h00

// update option bit positions
`define DUS_OB_CLKON    7
`define DUS_OB_ANAON    6
`define DUS_OB_TEMP     5
`define DUS_OB_LUT      4
`define DUS_OB_MODE2    3
`define DUS_OB_DISP     2
`define DUS_OB_ANAOFF   1
`define DUS_OB_CLKOFF   0

// ram content options
`define DUS_RAM_NORM    4'h0
`define DUS_RAM_ZERO    4'h4
`define DUS_RAM_INV     4'h8

// timing: settle time of clock and analog switching steps
`define DUS_CLK_NS      40
`define DUS_STEP_NS     200
`define DUS_STEP_CYC    ((`DUS_STEP_NS + `DUS_CLK_NS - 1) / `DUS_CLK_NS)

// sequencer states
`define DUS_ST_IDLE     3'h0
`define DUS_ST_CLKON    3'h1
`define DUS_ST_ANAON    3'h2
`define DUS_ST_TEMP     3'h3
`define DUS_ST_LUT      3'h4
`define DUS_ST_DISP     3'h5
`define DUS_ST_ANAOFF   3'h6
`define DUS_ST_CLKOFF   3'h7

`endif

// ===== rtl/dus_seq.v
`timescale 1ns/100ps
`include "dus_map.vh"

module dus_seq (
   input  wire       clk_i,         // system clock
   input  wire       rst_b_i,       // async reset, active low
   input  wire       start_i,       // one-cycle start pulse
   input  wire [7:0] opt_i,         // update option
   input  wire       temp_done_i,   // temperature load finished, pulse
   input  wire       lut_done_i,    // table load finished, pulse
   input  wire       disp_done_i,   // panel drive finished, pulse
   output wire       busy_o,        // sequence running
   output wire [2:0] step_o,        // current step
   output reg        clk_en_o,      // internal clock enabled
   output reg        analog_en_o,   // analog block enabled
   output reg        temp_req_o,    // temperature load request
   output reg        lut_req_o,     // table load request
   output reg        disp_req_o,    // panel drive request
   output reg        mode2_o        // display mode 2 selected
);

   localparam [2:0] ST_IDLE   = `DUS_ST_IDLE;
   localparam [2:0] ST_CLKON  = `DUS_ST_CLKON;
   localparam [2:0] ST_ANAON  = `DUS_ST_ANAON;
   localparam [2:0] ST_TEMP   = `DUS_ST_TEMP;
   localparam [2:0] ST_LUT    = `DUS_ST_LUT;
   localparam [2:0] ST_DISP   = `DUS_ST_DISP;
   localparam [2:0] ST_ANAOFF = `DUS_ST_ANAOFF;
   localparam [2:0] ST_CLKOFF = `DUS_ST_CLKOFF;
   localparam integer STEP_N  = `DUS_STEP_CYC;
   localparam [3:0] STEP_CYC  = STEP_N[3:0];

   reg  [2:0] st_r;
   reg  [7:0] opt_r;
   reg  [3:0] tmr_r;
   reg        step_on;

   assign busy_o = (st_r != ST_IDLE); // R7
   assign step_o = st_r;

   // option bits pick the steps, run in fixed order
   always @* begin
      case (st_r)
         ST_CLKON:  step_on = opt_r[`DUS_OB_CLKON];  // R2 R3 R4 R5
         ST_ANAON:  step_on = opt_r[`DUS_OB_ANAON];  // R4 R5
         ST_TEMP:   step_on = opt_r[`DUS_OB_TEMP];   // R2 R3
         ST_LUT:    step_on = opt_r[`DUS_OB_LUT];    // R2 R3
         ST_DISP:   step_on = opt_r[`DUS_OB_DISP];   // R4 R5
         ST_ANAOFF: step_on = opt_r[`DUS_OB_ANAOFF]; // R4 R5
         ST_CLKOFF: step_on = opt_r[`DUS_OB_CLKOFF]; // R2 R3 R4 R5
         default:   step_on = 1'b0;
      endcase
   end

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r        <= ST_IDLE;
         opt_r       <= 8'h00;
         tmr_r       <= 4'h0;
         clk_en_o    <= 1'b0;
         analog_en_o <= 1'b0;
         temp_req_o  <= 1'b0;
         lut_req_o   <= 1'b0;
         disp_req_o  <= 1'b0;
         mode2_o     <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (start_i) begin
                  opt_r   <= opt_i;
                  mode2_o <= opt_i[`DUS_OB_MODE2]; // R3 R5
                  tmr_r   <= 4'h0;
                  st_r    <= ST_CLKON;
               end
            end
            ST_CLKON, ST_ANAON, ST_ANAOFF, ST_CLKOFF: begin
               if (!step_on) begin
                  st_r <= (st_r == ST_CLKOFF) ? ST_IDLE : st_r + 3'h1;
               end else if (tmr_r == STEP_CYC - 4'h1) begin
                  tmr_r <= 4'h0;
                  st_r  <= (st_r == ST_CLKOFF) ? ST_IDLE : st_r + 3'h1;
               end else begin
                  tmr_r <= tmr_r + 4'h1;
                  if (st_r == ST_CLKON)
                     clk_en_o <= 1'b1;
                  if (st_r == ST_ANAON)
                     analog_en_o <= 1'b1;
                  if (st_r == ST_ANAOFF)
                     analog_en_o <= 1'b0;
                  if (st_r == ST_CLKOFF)
                     clk_en_o <= 1'b0;
               end
            end
            ST_TEMP: begin
               if (!step_on || (temp_req_o && temp_done_i)) begin
                  temp_req_o <= 1'b0;
                  st_r       <= ST_LUT;
               end else begin
                  temp_req_o <= 1'b1;
               end
            end
            ST_LUT: begin
               if (!step_on || (lut_req_o && lut_done_i)) begin
                  lut_req_o <= 1'b0;
                  st_r      <= ST_DISP;
               end else begin
                  lut_req_o <= 1'b1;
               end
            end
            ST_DISP: begin
               if (!step_on || (disp_req_o && disp_done_i)) begin
                  disp_req_o <= 1'b0;
                  st_r       <= ST_ANAOFF;
               end else begin
                  disp_req_o <= 1'b1;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

endmodule // dus_seq

// ===== rtl/dus_ctrl.v
`timescale 1ns/100ps
`include "dus_map.vh"

module dus_ctrl (
   input  wire        clk_i,         // system clock, 25 MHz
   input  wire        rst_b_i,       // async reset, active low
   input  wire        psel_i,        // apb select
   input  wire        penable_i,     // apb enable
   input  wire        pwrite_i,      // apb write
   input  wire [11:0] paddr_i,       // apb byte address
   input  wire [31:0] pwdata_i,      // apb write data
   output wire        pready_o,      // apb ready
   output reg  [31:0] prdata_o,      // apb read data
   output reg         pslverr_o,     // apb error, unmapped address
   input  wire        temp_done_i,   // temperature load finished
   input  wire        lut_done_i,    // table load finished
   input  wire        disp_done_i,   // panel drive finished
   input  wire        pix_vld_i,     // raw pixel valid
   input  wire        pix_bw_i,      // raw black-white plane bit
   input  wire        pix_red_i,     // raw red plane bit
   output wire        busy_o,        // update sequence running
   output wire        clk_en_o,      // internal clock enabled
   output wire        analog_en_o,   // analog block enabled
   output wire        temp_req_o,    // temperature load request
   output wire        lut_req_o,     // table load request
   output wire        disp_req_o,    // panel drive request
   output wire        mode2_o,       // display mode 2
   output reg         pix_vld_o,     // processed pixel valid
   output reg         pix_bw_o,      // effective black-white bit
   output reg         pix_red_o,     // effective red bit
   output reg         pix_white_o,   // pixel shows white
   output reg         pix_black_o,   // pixel shows black
   output reg         pix_is_red_o   // pixel shows red
);

   localparam [7:0] CMD_ACT  = `DUS_CMD_ACT;
   localparam [7:0] CMD_UPD1 = `DUS_CMD_UPD1;
   localparam [7:0] CMD_UPD2 = `DUS_CMD_UPD2;

   reg  [7:0] cmd_r;
   reg  [1:0] pidx_r;
   reg  [7:0] opt2_r;
   reg  [7:0] rama_r;
   reg  [7:0] ramb_r;
   reg        drop_r;
   reg        start_r;
   reg  [31:0] rd_nxt;
   reg        err_nxt;

   wire       setup_ph;
   wire       wr_acc;
   wire       tx_wr;
   wire       is_data;
   wire [7:0] tx_byte;
   wire       seq_busy;
   wire [2:0] seq_step;
   wire       drop_set;
   wire       drop_clr;
   wire [31:0] stat_word;

   // every register answers in its access cycle, so no wait states
   assign pready_o = 1'b1;
   assign setup_ph = psel_i & ~penable_i;
   assign wr_acc   = psel_i & penable_i & pwrite_i;
   assign tx_wr    = wr_acc & (paddr_i == `DUS_OFF_TX);
   assign is_data  = pwdata_i[`DUS_TX_DC_BIT]; // R9
   assign tx_byte  = pwdata_i[7:0];
   // start pulse keeps busy high in the cycle before the sequencer leaves idle
   assign busy_o   = seq_busy | start_r; // R7
   // a byte sent mid-sequence is refused and flagged; the sequencer runs on the option it latched at start
   assign drop_set = tx_wr & busy_o;
   assign drop_clr = wr_acc & (paddr_i == `DUS_OFF_STAT) & pwdata_i[`DUS_STAT_DROP];
   // status word: busy, drop flag and the sequencer step
   assign stat_word = {25'h0, seq_step, 2'h0, drop_r, busy_o};

   // read data and error decoded in setup, held in flops for the access cycle
   always @* begin
      rd_nxt  = 32'h0000_0000;
      err_nxt = 1'b0;
      case (paddr_i)
         `DUS_OFF_TX:    rd_nxt = {24'h00_0000, cmd_r};
         `DUS_OFF_CTRL1: rd_nxt = {16'h0000, ramb_r, rama_r};
         `DUS_OFF_CTRL2: rd_nxt = {24'h00_0000, opt2_r};
         `DUS_OFF_STAT:  rd_nxt = stat_word;
         default:        err_nxt = 1'b1;
      endcase
   end

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (setup_ph) begin
         // a write returns zero so no stale word is left on the bus
         prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_nxt;
         pslverr_o <= err_nxt;
      end
   end

   // byte interpreter: commands reset the parameter index, parameters fill fields
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_r   <= 8'h00;
         pidx_r  <= 2'h0;
         opt2_r  <= `DUS_RST_OPT2;
         rama_r  <= `DUS_RST_RAMA;
         ramb_r  <= `DUS_RST_RAMB;
         start_r <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (tx_wr && !busy_o) begin
            if (!is_data) begin // R9
               cmd_r  <= tx_byte;
               pidx_r <= 2'h0;
               if (tx_byte == CMD_ACT)
                  start_r <= 1'b1; // R7
            end else begin
               // index saturates so surplus parameters never wrap onto a field
               if (pidx_r != 2'h3)
                  pidx_r <= pidx_r + 2'h1;
               case (cmd_r)
                  CMD_UPD2: begin
                     if (pidx_r == 2'h0)
                        opt2_r <= tx_byte; // R1
                  end
                  CMD_UPD1: begin
                     if (pidx_r == 2'h0)
                        rama_r <= tx_byte; // R6
                     if (pidx_r == 2'h1)
                        ramb_r <= tx_byte;
                  end
                  default: begin
                     // other codes keep only the command byte
                  end
               endcase
            end
         end
      end
   end

   // bytes sent while busy are lost; set wins over clear
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         drop_r <= 1'b0;
      else if (drop_set)
         drop_r <= 1'b1; // R7
      else if (drop_clr)
         drop_r <= 1'b0;
   end

   // sequencer steps through the option bits in a fixed order
   dus_seq u_seq (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .start_i     (start_r),
      .opt_i       (opt2_r),
      .temp_done_i (temp_done_i),
      .lut_done_i  (lut_done_i),
      .disp_done_i (disp_done_i),
      .busy_o      (seq_busy),
      .step_o      (seq_step),
      .clk_en_o    (clk_en_o),
      .analog_en_o (analog_en_o),
      .temp_req_o  (temp_req_o),
      .lut_req_o   (lut_req_o),
      .disp_req_o  (disp_req_o),
      .mode2_o     (mode2_o)
   );

   // apply a plane's content option to one bit
   function ram_opt;
      input [3:0] opt;
      input       bit_in;
      begin
         case (opt)
            `DUS_RAM_NORM: ram_opt = bit_in; // R6
            `DUS_RAM_ZERO: ram_opt = 1'b0;   // R6
            `DUS_RAM_INV:  ram_opt = ~bit_in; // R6
            default:       ram_opt = bit_in;
         endcase
      end
   endfunction

   // plane 0 is black-white, plane 1 is red, each with its own option nibble
   wire [1:0] pix_raw;
   wire [1:0] pix_eff;
   wire       eff_bw;
   wire       eff_red;

   assign pix_raw = {pix_red_i, pix_bw_i};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_plane
         assign pix_eff[g] = ram_opt(rama_r[4*g+3:4*g], pix_raw[g]); // R6
      end
   endgenerate

   assign eff_bw  = pix_eff[0];
   assign eff_red = pix_eff[1];

   // red wins; otherwise the black-white bit picks white or black
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pix_vld_o    <= 1'b0;
         pix_bw_o     <= 1'b0;
         pix_red_o    <= 1'b0;
         pix_white_o  <= 1'b0;
         pix_black_o  <= 1'b0;
         pix_is_red_o <= 1'b0;
      end else begin
         pix_vld_o    <= pix_vld_i;
         pix_bw_o     <= eff_bw;
         pix_red_o    <= eff_red;
         pix_is_red_o <= pix_vld_i & eff_red;             // R8
         pix_white_o  <= pix_vld_i & ~eff_red & eff_bw;   // R8
         pix_black_o  <= pix_vld_i & ~eff_red & ~eff_bw;  // R8
      end
   end

endmodule // dus_ctrl

// ===== tb/dus_ctrl_checker.sv
`timescale 1ns/100ps
module dus_ctrl_checker (
   input wire        clk_i,        // clock
   input wire        rst_b_i,      // reset, active low
   input wire        psel_i,       // apb select
   input wire        penable_i,    // apb enable
   input wire        pwrite_i,     // apb write
   input wire [11:0] paddr_i,      // apb address
   input wire [31:0] pwdata_i,     // apb write data
   input wire        lut_done_i,   // table done
   input wire        pix_vld_i,    // raw pixel valid
   input wire        busy_o,       // busy
   input wire        clk_en_o,     // clock enable
   input wire        analog_en_o,  // analog enable
   input wire        temp_req_o,   // temp request
   input wire        lut_req_o,    // table request
   input wire        disp_req_o,   // drive request
   input wire        pix_vld_o,    // pixel valid
   input wire        pix_bw_o,     // bw bit
   input wire        pix_red_o,    // red bit
   input wire        pix_white_o,  // white
   input wire        pix_black_o,  // black
   input wire        pix_is_red_o  // red
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_go;
      psel_i && penable_i && pwrite_i && paddr_i == 12'h000 && pwdata_i[8:0] == 9'h020 && !busy_o;
   endsequence
   sequence s_lut_end;
      lut_req_o && lut_done_i;
   endsequence
   a_start_busy: assert property (s_go |=> busy_o [*8])
      else $error("busy too short after start");
   a_req_busy: assert property ((temp_req_o || lut_req_o || disp_req_o) |-> busy_o)
      else $error("step request outside busy");
   a_lut_clk: assert property (lut_req_o |-> clk_en_o)
      else $error("table load without clock");
   a_disp_analog: assert property (disp_req_o |-> clk_en_o && analog_en_o)
      else $error("panel drive without analog");
   a_lut_end: assert property (s_lut_end |=> !lut_req_o)
      else $error("table request stuck");
   a_clk_step: assert property ($rose(clk_en_o) |-> clk_en_o [*5])
      else $error("clock step too short");
   a_pix_lat: assert property (pix_vld_i |=> pix_vld_o)
      else $error("pixel latency wrong");
   a_pix_one: assert property (pix_vld_o |-> $onehot({pix_white_o, pix_black_o, pix_is_red_o}))
      else $error("pixel colour not unique");
   a_red_wins: assert property (pix_vld_o |-> pix_is_red_o == pix_red_o)
      else $error("red colour wrong");
   a_white_bw: assert property (pix_vld_o && !pix_red_o |-> pix_white_o == pix_bw_o)
      else $error("white colour wrong");
endmodule // dus_ctrl_checker

bind dus_ctrl dus_ctrl_checker u_chk (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .lut_done_i, .pix_vld_i, .busy_o, .clk_en_o, .analog_en_o,
   .temp_req_o, .lut_req_o, .disp_req_o, .pix_vld_o, .pix_bw_o, .pix_red_o,
   .pix_white_o, .pix_black_o, .pix_is_red_o);

// ===== tb/dus_unit_model.sv
`timescale 1ns/100ps
module dus_unit_model (
   input  wire clk_i,       // clock
   input  wire rst_b_i,     // reset, active low
   input  wire temp_req_i,  // temp request
   input  wire lut_req_i,   // table request
   input  wire disp_req_i,  // drive request
   output reg  temp_done_o, // temp done pulse
   output reg  lut_done_o,  // table done pulse
   output reg  disp_done_o  // drive done pulse
);
   integer   seed = 32'h3e18fd2f;
   reg [2:0] cnt_r;
   wire      pend = (temp_req_i | lut_req_i | disp_req_i) &
                    ~(temp_done_o | lut_done_o | disp_done_o);
   // random latency per request, zero means prompt answer
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 3'h0;
         {temp_done_o, lut_done_o, disp_done_o} <= 3'h0;
      end else begin
         {temp_done_o, lut_done_o, disp_done_o} <= (pend && cnt_r == 3'h0) ?
            {temp_req_i, lut_req_i, disp_req_i} : 3'h0;
         if (!pend) cnt_r <= 3'($random(seed));
         else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      end
   end
endmodule // dus_unit_model

// ===== tb/display_update_sequence_ctrl_test.sv
`timescale 1ns/100ps
module display_update_sequence_ctrl_test;
   reg clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, pon = 0;
   reg pix_vld_i = 0, pix_bw_i = 0, pix_red_i = 0, ord_bad;
   reg [11:0] paddr_i = 12'h000;
   reg [31:0] pwdata_i = 32'h0;
   reg [7:0] ra = 8'h00, b, opts [0:5];
   reg [4:0] seen;
   reg [5:0] pq [$];
   reg [32:0] q [$];
   wire pready_o, pslverr_o, busy_o, clk_en_o, analog_en_o, temp_req_o, lut_req_o, disp_req_o;
   wire mode2_o, pix_vld_o, pix_bw_o, pix_red_o, pix_white_o, pix_black_o, pix_is_red_o;
   wire temp_done_i, lut_done_i, disp_done_i;
   wire [31:0] prdata_o;
   integer seed, n_fail = 0, checks = 0, cyc = 0, i;
   always #20 clk_i = ~clk_i;
   dus_ctrl dut (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .pready_o, .prdata_o, .pslverr_o, .temp_done_i, .lut_done_i, .disp_done_i, .pix_vld_i,
      .pix_bw_i, .pix_red_i, .busy_o, .clk_en_o, .analog_en_o, .temp_req_o, .lut_req_o,
      .disp_req_o, .mode2_o, .pix_vld_o, .pix_bw_o, .pix_red_o, .pix_white_o, .pix_black_o,
      .pix_is_red_o);
   dus_unit_model u_unit (.clk_i, .rst_b_i, .temp_req_i(temp_req_o), .lut_req_i(lut_req_o),
      .disp_req_i(disp_req_o), .temp_done_o(temp_done_i), .lut_done_o(lut_done_i),
      .disp_done_o(disp_done_i));
   task end_sim;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task check(input [63:0] sv, input [63:0] ev, input [95:0] nm);
      checks = checks + 1;
      if (sv !== ev) begin
         n_fail = n_fail + 1;
         $display("[FAIL] %0s exp %h seen %h", nm, ev, sv);
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d, input [32:0] e);
      @(posedge clk_i);
      psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      if (!w) q.push_back(e);
      @(posedge clk_i);
      penable_i <= 1;
      @(posedge clk_i);
      while (!pready_o) @(posedge clk_i);
      psel_i <= 0; penable_i <= 0;
   endtask
   task tx(input dc, input [7:0] v);
      apb(12'h000, 1, {23'h0, dc, v}, 33'h0);
   endtask
   function eff(input [3:0] o, input v);
      eff = (o == 4'h4) ? 1'b0 : (o == 4'h8) ? ~v : v;
   endfunction
   always @(posedge clk_i) begin
      if (pix_vld_i && rst_b_i)
         pq.push_back({1'b1, eff(ra[3:0], pix_bw_i), eff(ra[7:4], pix_red_i),
            !eff(ra[7:4], pix_red_i) && eff(ra[3:0], pix_bw_i),
            !eff(ra[7:4], pix_red_i) && !eff(ra[3:0], pix_bw_i), eff(ra[7:4], pix_red_i)});
      pix_vld_i <= pon;
      {pix_bw_i, pix_red_i} <= 2'($random(seed));
      if (psel_i && penable_i && pready_o && !pwrite_i)
         check({pslverr_o, pslverr_o ? 32'h0 : prdata_o}, q.pop_front(), "apb read");
      if (analog_en_o && !clk_en_o || temp_req_o && seen[2]) ord_bad = 1;
      seen = seen | {analog_en_o, temp_req_o, lut_req_o, disp_req_o,
                     mode2_o & (lut_req_o | disp_req_o)};
      cyc = cyc + 1;
      if (cyc > 20000) begin
         n_fail = n_fail + 1;
         end_sim;
      end
   end
   always @(negedge clk_i) begin
      if (pix_vld_o && rst_b_i)
         check({pix_vld_o, pix_bw_o, pix_red_o, pix_white_o, pix_black_o, pix_is_red_o},
            pq.pop_front(), "pixel");
   end
   initial begin
      seed = 32'h3e18fd2f;
      opts = '{8'h91, 8'hB1, 8'h99, 8'hB9, 8'hC7, 8'hCF};
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1;
      apb(12'h008, 0, 0, {1'b0, 32'hFF});
      apb(12'h004, 0, 0, 33'h0);
      apb(12'h010, 0, 0, {1'b1, 32'h0});
      pon <= 1;
      repeat (30) @(posedge clk_i);
      for (i = 0; i < 2; i = i + 1) begin
         pon <= 0;
         b = 8'($random(seed));
         tx(0, 8'h21);
         tx(1, i ? 8'h48 : 8'h84);
         tx(1, b);
         apb(12'h004, 0, 0, {17'h0, b, i ? 8'h48 : 8'h84});
         ra = i ? 8'h48 : 8'h84;
         pon <= 1;
         repeat (40) @(posedge clk_i);
      end
      for (i = 0; i < 6; i = i + 1) begin
         tx(0, 8'h22);
         tx(1, opts[i]);
         apb(12'h008, 0, 0, {25'h0, opts[i]});
         seen = 0;
         ord_bad = 0;
         tx(0, 8'h20);
         tx(0, 8'h22);
         while (busy_o) @(posedge clk_i);
         @(negedge clk_i);
         check({ord_bad, clk_en_o, analog_en_o, seen}, {3'h0, opts[i][6], opts[i][5],
            opts[i][4], opts[i][2], opts[i][3]}, "steps");
         apb(12'h00C, 0, 0, {1'b0, 32'h2});
         apb(12'h00C, 1, 32'h2, 33'h0);
      end
      pon <= 0;
      apb(12'h00C, 0, 0, 33'h0);
      apb(12'h008, 0, 0, {25'h0, 8'hCF});
      check(pq.size(), 0, "pixel left");
      end_sim;
   end
endmodule // display_update_sequence_ctrl_test
